// >>> core/tmr_params.svh
// Purpose: constants of the temperature measurement result map
// Assumes: 8-bit register addresses, encoded temperatures in registers
// Notes:   guarded against double inclusion
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TMR_OFS_LOCAL_WHOLE  8'h00
`define TMR_OFS_R1_WHOLE     8'h01
`define TMR_OFS_R1_FRAC      8'h10
`define TMR_OFS_R2_WHOLE     8'h30
`define TMR_OFS_R2_FRAC      8'h33
`define TMR_OFS_STATUS1      8'h02
`define TMR_OFS_STATUS2      8'h23
`define TMR_OFS_CONFIG1      8'h03
`define TMR_OFS_LIM_HI_BASE  8'h50
`define TMR_OFS_LIM_LO_BASE  8'h54
`define TMR_OFS_LIM_TH_BASE  8'h58

// ****************************************************************
// field positions
// ****************************************************************
`define TMR_CFG_REMAP_BIT    3
`define TMR_CFG_RANGE_BIT    2
`define TMR_CFG_ALT_BIT      5
`define TMR_ST1_BUSY         7
`define TMR_ST2_ALARM        0

// ****************************************************************
// reset values and range limits (quarter degrees)
// ****************************************************************
`define TMR_CONFIG1_RST      8'h00
`define TMR_LIM_HI_RST       8'h55
`define TMR_LIM_LO_RST       8'h00
`define TMR_LIM_TH_RST       8'h55
`define TMR_EXT_OFFSET_Q     12'sh100
`define TMR_MAX_DEF_Q        12'sh1ff
`define TMR_MAX_EXT_Q        12'sh3ff
`define TMR_ADDR_BASE        7'h18

`endif

// >>> core/tmr_pkg.sv
// Purpose: shared types of the temperature measurement result map
// Assumes: three channels, quarter-degree converter output
// Notes:   constants live in tmr_params.svh
package tmr_pkg;

	typedef enum logic [1:0] {CH_LOCAL, CH_REMOTE1, CH_REMOTE2} tmr_chan_t;

	typedef enum {SQ_START, SQ_WAIT} tmr_seq_state_t;

	// converter answer: signed quarter degrees and diode open flag
	typedef struct packed {
		logic               open;
		logic signed [10:0] temp_q;
	} tmr_adc_res_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tmr_reg_req_t;

endpackage

// >>> core/tmr_sequencer.sv
// Purpose: free-running channel sequencer for the converter
// Assumes: converter answers each start with one done pulse
// Notes:   order local, remote one, local, remote two
`timescale 1ns/1ps
module tmr_sequencer
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              range_ext,
	input  wire logic              conv_done,
	output tmr_pkg::tmr_chan_t     chan,
	output logic                   conv_start,
	output logic                   range_used,
	output logic                   busy
);
	import tmr_pkg::*;

	tmr_seq_state_t state_reg;
	logic [1:0]     slot_reg;

	// ****************************************************************
	// sequencing
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg  <= SQ_START;
			slot_reg   <= 2'h0;
			conv_start <= 1'b0;
			busy       <= 1'b0;
			chan       <= CH_LOCAL;
			range_used <= 1'b0;
		end
		else
		begin
			conv_start <= 1'b0;
			unique case (state_reg)
				SQ_START:
				begin
					// restart needs no host request
					conv_start <= 1'b1;
					busy       <= 1'b1;
					// range sampled per conversion, so a change acts from the next start
					range_used <= range_ext;
					if (!slot_reg[0])
						chan <= CH_LOCAL;
					else if (!slot_reg[1])
						chan <= CH_REMOTE1;
					else
						chan <= CH_REMOTE2;
					state_reg <= SQ_WAIT;
				end
				SQ_WAIT:
				begin
					if (conv_done)
					begin
						busy      <= 1'b0;
						slot_reg  <= slot_reg + 2'h1;
						state_reg <= SQ_START;
					end
				end
			endcase
		end
	end

endmodule // tmr_sequencer

// >>> core/tmr_top.sv
// Purpose: measurement sequencer and result register map
// Assumes: converter on same clock, pins are asynchronous
// Notes:   register reads answer one cycle after the strobe
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_top
(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire tmr_pkg::tmr_reg_req_t reg_req,
	output logic [7:0]               reg_rdata,
	output logic                     reg_rvalid,
	input  wire logic                adc_done,
	input  wire tmr_pkg::tmr_adc_res_t adc_res,
	output logic                     adc_start,
	output tmr_pkg::tmr_chan_t       adc_chan,
	output logic                     adc_range_ext,
	input  wire logic [1:0]          addr_select_a,
	input  wire logic [1:0]          addr_select_b,
	output logic [6:0]               target_addr,
	output logic                     alarm_n,
	output logic                     overtemp_shutdown_n
);
	import tmr_pkg::*;

	logic [7:0] config1_reg;
	logic [7:0] whole_reg [3];
	logic [1:0] frac_reg  [3];
	logic [7:0] hold_reg  [3];
	logic [2:0] hold_on_reg;
	logic [7:0] lim_hi_reg [3];
	logic [7:0] lim_lo_reg [3];
	logic [7:0] lim_th_reg [3];
	logic [2:0] hi_cond_reg, lo_cond_reg, th_cond_reg, open_cond_reg;
	logic [2:0] hi_flag_reg, lo_flag_reg, open_flag_reg;
	logic [1:0] sel_a_meta, sel_a_sync, sel_b_meta, sel_b_sync;
	logic       busy;
	logic [9:0] enc_next;
	logic [7:0] rd_next;
	logic [1:0] ch_idx;
	logic [1:0] r1_view;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// signed quarter degrees to {whole, fraction} with range clamp
	function automatic logic [9:0] encode(input logic signed [10:0] t,
		input logic ext);
		logic signed [11:0] v;
		v = {t[10], t} + (ext ? `TMR_EXT_OFFSET_Q : 12'sh000);
		if (v < 12'sh000)
			v = 12'sh000;
		else if (ext && v > `TMR_MAX_EXT_Q)
			v = `TMR_MAX_EXT_Q;
		else if (!ext && v > `TMR_MAX_DEF_Q)
			v = `TMR_MAX_DEF_Q;
		return v[9:0];
	endfunction

	// nine pin combinations, each pin low, high or floating
	function automatic logic [6:0] pin_addr(input logic [1:0] a,
		input logic [1:0] b);
		logic [3:0] idx;
		idx = 4'(a) * 4'h3 + 4'(b);
		return `TMR_ADDR_BASE + 7'(idx);
	endfunction

	// remote-one addresses show remote two while remap is set
	function automatic logic [1:0] remote1_view(input logic remap);
		return remap ? 2'd2 : 2'd1;
	endfunction

	assign r1_view  = remote1_view(config1_reg[`TMR_CFG_REMAP_BIT]);
	assign ch_idx   = 2'(adc_chan);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	tmr_sequencer u_seq
	(
		.clk        (clk),
		.rst        (rst),
		.range_ext  (config1_reg[`TMR_CFG_RANGE_BIT]),
		.conv_done  (adc_done),
		.chan       (adc_chan),
		.conv_start (adc_start),
		.range_used (adc_range_ext),
		.busy       (busy)
	);

	// ****************************************************************
	// address pins
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		sel_a_meta  <= addr_select_a;
		sel_a_sync  <= sel_a_meta;
		sel_b_meta  <= addr_select_b;
		sel_b_sync  <= sel_b_meta;
		if (rst)
			target_addr <= `TMR_ADDR_BASE;
		else
			target_addr <= pin_addr(sel_a_sync, sel_b_sync);
	end

	// ****************************************************************
	// configuration
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
			config1_reg <= `TMR_CONFIG1_RST;
		else if (reg_req.wr && reg_req.addr == `TMR_OFS_CONFIG1)
			config1_reg <= reg_req.wdata;
	end

	// ****************************************************************
	// value registers and limit checks
	// ****************************************************************
	assign enc_next = encode(adc_res.temp_q, adc_range_ext);

	generate
		for (genvar i = 0; i < 3; i++)
		begin : g_chan
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					lim_hi_reg[i] <= `TMR_LIM_HI_RST;
					lim_lo_reg[i] <= `TMR_LIM_LO_RST;
					lim_th_reg[i] <= `TMR_LIM_TH_RST;
				end
				else if (reg_req.wr)
				begin
					if (reg_req.addr == `TMR_OFS_LIM_HI_BASE + 8'(i))
						lim_hi_reg[i] <= reg_req.wdata;
					if (reg_req.addr == `TMR_OFS_LIM_LO_BASE + 8'(i))
						lim_lo_reg[i] <= reg_req.wdata;
					if (reg_req.addr == `TMR_OFS_LIM_TH_BASE + 8'(i))
						lim_th_reg[i] <= reg_req.wdata;
				end
			end

			// whole and fraction written in one edge, never half-new
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					whole_reg[i]     <= 8'h00;
					frac_reg[i]      <= 2'h0;
					hi_cond_reg[i]   <= 1'b0;
					lo_cond_reg[i]   <= 1'b0;
					th_cond_reg[i]   <= 1'b0;
					open_cond_reg[i] <= 1'b0;
				end
				else if (adc_done && ch_idx == 2'(i))
				begin
					whole_reg[i]     <= enc_next[9:2];
					frac_reg[i]      <= (i == 0) ? 2'h0 : enc_next[1:0];
					hi_cond_reg[i]   <= enc_next[9:2] > lim_hi_reg[i];
					lo_cond_reg[i]   <= enc_next[9:2] < lim_lo_reg[i];
					th_cond_reg[i]   <= enc_next[9:2] > lim_th_reg[i];
					open_cond_reg[i] <= (i != 0) && adc_res.open;
				end
			end

			// sticky flags; a new trip beats a clearing read
			always_ff @(posedge clk)
			begin
				logic clr;
				clr = reg_req.rd && (reg_req.addr ==
					((i == 2) ? `TMR_OFS_STATUS2 : `TMR_OFS_STATUS1));
				if (rst)
				begin
					hi_flag_reg[i]   <= 1'b0;
					lo_flag_reg[i]   <= 1'b0;
					open_flag_reg[i] <= 1'b0;
				end
				else
				begin
					hi_flag_reg[i]   <= hi_cond_reg[i] |
						(hi_flag_reg[i] & ~clr);
					lo_flag_reg[i]   <= lo_cond_reg[i] |
						(lo_flag_reg[i] & ~clr);
					open_flag_reg[i] <= open_cond_reg[i] |
						(open_flag_reg[i] & ~clr);
				end
			end

			// fraction read freezes whole byte until it is read
			always_ff @(posedge clk)
			begin
				logic frac_hit, whole_hit;
				frac_hit  = reg_req.rd && i != 0 &&
					((reg_req.addr == `TMR_OFS_R1_FRAC && r1_view == 2'(i)) ||
					(reg_req.addr == `TMR_OFS_R2_FRAC && i == 2));
				whole_hit = reg_req.rd && i != 0 &&
					((reg_req.addr == `TMR_OFS_R1_WHOLE && r1_view == 2'(i)) ||
					(reg_req.addr == `TMR_OFS_R2_WHOLE && i == 2));
				if (rst)
				begin
					hold_on_reg[i] <= 1'b0;
					hold_reg[i]    <= 8'h00;
				end
				else if (frac_hit)
				begin
					hold_on_reg[i] <= 1'b1;
					hold_reg[i]    <= whole_reg[i];
				end
				else if (whole_hit)
					hold_on_reg[i] <= 1'b0;
			end
		end
	endgenerate

	// ****************************************************************
	// register reads
	// ****************************************************************
	always_comb
	begin
		rd_next = 8'h00;
		unique case (reg_req.addr)
			`TMR_OFS_LOCAL_WHOLE: rd_next = whole_reg[0];
			`TMR_OFS_R1_WHOLE:
				rd_next = hold_on_reg[r1_view] ? hold_reg[r1_view]
					: whole_reg[r1_view];
			`TMR_OFS_R1_FRAC:
				rd_next = {frac_reg[r1_view], 6'h00};
			`TMR_OFS_R2_WHOLE:
				rd_next = hold_on_reg[2] ? hold_reg[2] : whole_reg[2];
			`TMR_OFS_R2_FRAC:    rd_next = {frac_reg[2], 6'h00};
			`TMR_OFS_CONFIG1:    rd_next = config1_reg;
			`TMR_OFS_STATUS1:
				rd_next = {busy, hi_flag_reg[0], lo_flag_reg[0],
					hi_flag_reg[1], lo_flag_reg[1], open_flag_reg[1],
					th_cond_reg[1], th_cond_reg[0]};
			`TMR_OFS_STATUS2:
				rd_next = {3'h0, hi_flag_reg[2], lo_flag_reg[2],
					open_flag_reg[2], th_cond_reg[2], ~alarm_n};
			default:
			begin
				for (int k = 0; k < 3; k++)
				begin
					if (reg_req.addr == `TMR_OFS_LIM_HI_BASE + 8'(k))
						rd_next = lim_hi_reg[k];
					if (reg_req.addr == `TMR_OFS_LIM_LO_BASE + 8'(k))
						rd_next = lim_lo_reg[k];
					if (reg_req.addr == `TMR_OFS_LIM_TH_BASE + 8'(k))
						rd_next = lim_th_reg[k];
				end
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_req.rd;
			if (reg_req.rd)
				reg_rdata <= rd_next;
		end
	end

	// ****************************************************************
	// alarm and shutdown pins
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			alarm_n             <= 1'b1;
			overtemp_shutdown_n <= 1'b1;
		end
		else
		begin
			// live comparator: fan control needs no host service
			overtemp_shutdown_n <= ~(|th_cond_reg);
			if (config1_reg[`TMR_CFG_ALT_BIT])
				alarm_n <= ~(|hi_cond_reg);
			else
				alarm_n <= ~(|hi_flag_reg | |lo_flag_reg
					| |open_flag_reg);
		end
	end

endmodule // tmr_top

// >>> bench/tmr_monitor.sv
// Purpose: port checks of the measurement result map
// Assumes: converter gives one done per start
// Notes:   bound onto tmr_top
`timescale 1ns/1ps
module tmr_monitor
(
	input wire logic                  clk,
	input wire logic                  rst,
	input wire tmr_pkg::tmr_reg_req_t reg_req,
	input wire logic [7:0]            reg_rdata,
	input wire logic                  reg_rvalid,
	input wire logic                  adc_done,
	input wire logic                  adc_start,
	input wire tmr_pkg::tmr_chan_t    adc_chan,
	input wire logic [1:0]            addr_select_a,
	input wire logic [1:0]            addr_select_b,
	input wire logic [6:0]            target_addr,
	input wire logic                  alarm_n,
	input wire logic                  overtemp_shutdown_n
);
	import tmr_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ****************************************
	// assertions
	// ****************************************
	AST_START_PULSE: assert property (
		adc_start |=> !adc_start) else $error("start pulse too long");
	AST_RESTART: assert property (
		adc_done |-> ##[1:2] adc_start) else $error("no restart");
	AST_CHAN_ORDER: assert property (
		adc_start && $past(adc_chan) != CH_LOCAL |-> adc_chan == CH_LOCAL)
		else $error("local not between remotes");
	AST_CHAN_HOLD: assert property (
		!adc_start |-> $stable(adc_chan)) else $error("channel moved");
	AST_READ_ANSWER: assert property (
		reg_rvalid == $past(reg_req.rd)) else $error("read answer late");
	AST_FRAC_ZERO: assert property (
		reg_rvalid && ($past(reg_req.addr) == 8'h10
		|| $past(reg_req.addr) == 8'h33) |-> reg_rdata[5:0] == 6'h00)
		else $error("fraction low bits set");
	AST_TARGET: assert property (
		($stable(addr_select_a) && $stable(addr_select_b))[*5] |->
		target_addr == 7'h18 + 7'(addr_select_a) * 7'd3
		+ 7'(addr_select_b)) else $error("bus address wrong");
	AST_ALARM_CAUSE: assert property (
		$fell(alarm_n) |-> $past(adc_done, 1) || $past(adc_done, 2)
		|| $past(adc_done, 3)) else $error("alarm without result");
	AST_SHUT_CAUSE: assert property (
		$changed(overtemp_shutdown_n) |-> $past(adc_done, 1)
		|| $past(adc_done, 2) || $past(adc_done, 3))
		else $error("shutdown moved without result");
endmodule // tmr_monitor

bind tmr_top tmr_monitor u_mon (.clk(clk), .rst(rst), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .adc_done(adc_done),
	.adc_start(adc_start), .adc_chan(adc_chan),
	.addr_select_a(addr_select_a), .addr_select_b(addr_select_b),
	.target_addr(target_addr), .alarm_n(alarm_n),
	.overtemp_shutdown_n(overtemp_shutdown_n));

// >>> bench/tmr_adc_model.sv
// Purpose: converter model answering each start once
// Assumes: per-channel temperatures set by the bench
// Notes:   slow stretches conversion time
`timescale 1ns/1ps
module tmr_adc_model
(
	input wire logic               clk,
	input wire logic               rst,
	input wire logic               adc_start,
	input wire tmr_pkg::tmr_chan_t adc_chan,
	input wire logic               slow,
	input wire logic               open1,
	input wire logic [10:0]        t_loc,
	input wire logic [10:0]        t_r1,
	input wire logic [10:0]        t_r2,
	output logic                   adc_done,
	output tmr_pkg::tmr_adc_res_t  adc_res
);
	import tmr_pkg::*;
	logic [7:0] cnt;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt <= 8'h00;
			adc_done <= 1'b0;
			adc_res <= '0;
		end
		else
		begin
			adc_done <= 1'b0;
			if (adc_start)
				cnt <= slow ? 8'h14 : 8'h03;
			else if (cnt == 8'h01)
			begin
				cnt <= 8'h00;
				adc_done <= 1'b1;
				case (adc_chan)
				CH_REMOTE1: adc_res <= {open1, t_r1};
				CH_REMOTE2: adc_res <= {1'b0, t_r2};
				default:    adc_res <= {1'b0, t_loc};
				endcase
			end
			else if (cnt != 8'h00)
				cnt <= cnt - 8'h01;
			// result not held past its cycle
			if (adc_done)
				adc_res <= ~adc_res;
		end
	end
endmodule // tmr_adc_model

// >>> bench/test_temp_measure_result_map.sv
// Purpose: self-checking bench of the result map
// Assumes: 20 MHz clock, synchronous reset
// Notes:   table rows, then hand cases
`timescale 1ns/1ps
module test_temp_measure_result_map;
	import tmr_pkg::*;
	typedef struct packed {
		logic [10:0] tl, t1, t2;
		logic [7:0]  cfg;
		logic [39:0] exp;
	} tmr_row_t;
	logic clk = 1'b0;
	logic rst, reg_rvalid, adc_done, adc_start, adc_range_ext;
	logic alarm_n, overtemp_shutdown_n, slow, open1;
	tmr_reg_req_t reg_req;
	tmr_adc_res_t adc_res;
	tmr_chan_t    adc_chan;
	logic [7:0]   reg_rdata, d;
	logic [1:0]   addr_select_a, addr_select_b;
	logic [6:0]   target_addr;
	logic [10:0]  t_loc, t_r1, t_r2;
	int num_errors = 0;
	int check_count = 0;
	// read order: fraction before whole
	logic [7:0] adr [5] = '{8'h10, 8'h01, 8'h33, 8'h30, 8'h00};
	tmr_row_t rows [4] = '{
		'{11'h064, 11'h0a3, 11'h029, 8'h00, 40'hc0_28_40_0a_19},
		'{11'h064, 11'h0a3, 11'h029, 8'h08, 40'h40_0a_40_0a_19},
		'{11'h7b0, 11'h25a, 11'h700, 8'h04, 40'h80_d6_00_00_2c},
		'{11'h7ec, 11'h320, 11'h003, 8'h00, 40'hc0_7f_c0_00_00}};
	always #25 clk = ~clk;
	tmr_top uut (.clk(clk), .rst(rst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.adc_done(adc_done), .adc_res(adc_res), .adc_start(adc_start),
		.adc_chan(adc_chan), .adc_range_ext(adc_range_ext),
		.addr_select_a(addr_select_a), .addr_select_b(addr_select_b),
		.target_addr(target_addr), .alarm_n(alarm_n),
		.overtemp_shutdown_n(overtemp_shutdown_n));
	tmr_adc_model u_adc (.clk(clk), .rst(rst), .adc_start(adc_start),
		.adc_chan(adc_chan), .slow(slow), .open1(open1), .t_loc(t_loc),
		.t_r1(t_r1), .t_r2(t_r2), .adc_done(adc_done), .adc_res(adc_res));
	// ****************************************
	// tasks
	// ****************************************
	task check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		#1 reg_req.rd = 1'b1;
		reg_req.addr = a;
		@(posedge clk);
		#1 reg_req.rd = 1'b0;
		check({7'h00, reg_rvalid}, 8'h01);
		v = reg_rdata;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		#1 reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = v;
		@(posedge clk);
		#1 reg_req.wr = 1'b0;
	endtask
	task rounds(input int n);
		int k;
		k = 0;
		for (int i = 0; i < 3000 && k < n; i++)
		begin
			@(posedge clk);
			#1;
			if (adc_start === 1'b1)
				k++;
		end
		// a stalled sequencer runs the limit out and counts here
		check(8'(k), 8'(n));
	endtask
	task close_out;
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		close_out;
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		rst = 1'b1;
		reg_req = '0;
		slow = 1'b0;
		open1 = 1'b0;
		{t_loc, t_r1, t_r2} = {11'h064, 11'h0a3, 11'h029};
		{addr_select_a, addr_select_b} = 4'h0;
		repeat (6) @(posedge clk);
		#1 check({4'h0, reg_rvalid, alarm_n, overtemp_shutdown_n,
			adc_start}, 8'h06);
		rst = 1'b0;
		for (int a = 0; a < 3; a++)
			for (int b = 0; b < 3; b++)
			begin
				addr_select_a = 2'(a);
				addr_select_b = 2'(b);
				repeat (6) @(posedge clk);
				#1 check({1'b0, target_addr}, 8'(24 + a * 3 + b));
			end
		foreach (rows[i])
		begin
			{t_loc, t_r1, t_r2} = {rows[i].tl, rows[i].t1, rows[i].t2};
			slow = 1'(i % 2);
			wr(8'h03, rows[i].cfg);
			rounds(5);
			check({7'h00, adc_range_ext}, {7'h00, rows[i].cfg[2]});
			for (int j = 0; j < 5; j++)
			begin
				rd(adr[j], d);
				check(d, rows[i].exp[8 * (4 - j) +: 8]);
			end
		end
		check({6'h00, alarm_n, overtemp_shutdown_n}, 8'h00);
		// whole byte must stay frozen across new conversions
		rd(8'h10, d);
		check(d, 8'hc0);
		t_r1 = 11'h0a3;
		t_loc = 11'h064;
		rounds(5);
		rd(8'h01, d);
		check(d, 8'h7f);
		rd(8'h01, d);
		check(d, 8'h28);
		check({7'h00, overtemp_shutdown_n}, 8'h01);
		check({7'h00, alarm_n}, 8'h00);
		rd(8'h02, d);
		check(d & 8'h7f, 8'h10);
		rd(8'h23, d);
		check(d, 8'h00);
		repeat (3) @(posedge clk);
		#1 check({7'h00, alarm_n}, 8'h01);
		open1 = 1'b1;
		// six starts: remote one surely done and the pin settled
		rounds(6);
		check({7'h00, alarm_n}, 8'h00);
		rd(8'h7e, d);
		check(d, 8'h00);
		wr(8'h00, 8'hff);
		rd(8'h00, d);
		check(d, 8'h19);
		// alternate pin mode: live high limits only, open ignored
		wr(8'h03, 8'h20);
		repeat (3) @(posedge clk);
		#1 check({7'h00, alarm_n}, 8'h01);
		t_r1 = 11'h200;
		rounds(6);
		check({7'h00, alarm_n}, 8'h00);
		check({7'h00, overtemp_shutdown_n}, 8'h00);
		t_r1 = 11'h0a3;
		rounds(6);
		check({7'h00, alarm_n}, 8'h01);
		// mid-run reset: config and value registers back to defaults
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 check({4'h0, reg_rvalid, alarm_n, overtemp_shutdown_n,
			adc_start}, 8'h06);
		rst = 1'b0;
		rd(8'h03, d);
		check(d, 8'h00);
		rd(8'h00, d);
		check(d, 8'h00);
		close_out;
	end
endmodule // test_temp_measure_result_map
